// [core/modem_cfg_pkg.sv]
// constants shared by the modem configuration block and its timeout timer
// assumes a 32-bit AXI4-Lite bus, one aligned word per register
package modem_cfg_pkg;
	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_SPACING_MANTISSA = 8'h14;
	localparam logic [7:0] IDX_MODULATION_DEVIATION = 8'h15;
	localparam logic [7:0] IDX_RX_TIMEOUT_CONTROL = 8'h16;
	localparam logic [7:0] IDX_SPACING_EXPONENT = 8'h00;
	localparam logic [7:0] IDX_CHANNEL_NUMBER = 8'h01;
	localparam logic [7:0] IDX_BASE_FREQUENCY = 8'h02;
	localparam logic [7:0] IDX_MODEM_MODE = 8'h03;
	localparam logic [7:0] IDX_SPACING_STATUS = 8'h04;
	localparam logic [7:0] IDX_FREQUENCY_STATUS = 8'h05;
	localparam logic [7:0] IDX_DEVIATION_STATUS = 8'h06;
	localparam logic [7:0] IDX_TIMER_STATUS = 8'h07;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_SPACING_MANTISSA = 8'hF8;
	localparam logic [7:0] RST_MODULATION_DEVIATION = 8'h47;
	localparam logic [7:0] RST_RX_TIMEOUT_CONTROL = 8'h07;
	localparam logic [1:0] RST_SPACING_EXPONENT = 2'h2;
	localparam logic [7:0] RST_CHANNEL_NUMBER = 8'h00;
	localparam logic [23:0] RST_BASE_FREQUENCY = 24'h000000;
	localparam logic [2:0] RST_MODEM_MODE = 3'h0;
	// ==========================================================
	// field layout and masks (reserved bits read zero)
	localparam logic [7:0] MASK_DEVIATION = 8'h77;
	localparam logic [7:0] MASK_RX_TIMEOUT = 8'h1F;
	localparam int DEV_EXP_LSB = 4;
	localparam int TO_RSSI_BIT = 4;
	localparam int TO_QUAL_BIT = 3;
	localparam logic [9:0] SPACING_OFFSET = 10'h100;
	localparam logic [3:0] DEVIATION_OFFSET = 4'h8;
	localparam logic [2:0] RX_TIME_NONE = 3'h7;
	// ==========================================================
	// timeout coefficients in units of 0.0001 ms at a 26 MHz reference
	localparam longint COEF_RES0 = 36058;
	localparam longint COEF_RES1 = 180288;
	localparam longint COEF_RES2 = 324519;
	localparam longint COEF_RES3 = 468750;
	localparam int CLK_MHZ = 10;
	// C*26/X ms at X MHz is C*26/10 cycles; rounded down (shortest time)
	localparam int CYC_RES0 = int'(COEF_RES0 * 26 / 10);
	localparam int CYC_RES1 = int'(COEF_RES1 * 26 / 10);
	localparam int CYC_RES2 = int'(COEF_RES2 * 26 / 10);
	localparam int CYC_RES3 = int'(COEF_RES3 * 26 / 10);
	localparam int TIMER_W = 21;
	// ==========================================================
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		TMR_IDLE = 3'b001,
		TMR_COUNT = 3'b010,
		TMR_DONE = 3'b100
	} timer_state_type;
endpackage

// [core/rx_timeout_timer.sv]
// receive timeout timer with sync and preamble qualifiers
// assumes all inputs synchronous to ref_clk_in
`timescale 1ns/1ps
module rx_timeout_timer #(
	parameter int RES0_CYCLES = modem_cfg_pkg::CYC_RES0,
	parameter int RES1_CYCLES = modem_cfg_pkg::CYC_RES1,
	parameter int RES2_CYCLES = modem_cfg_pkg::CYC_RES2,
	parameter int RES3_CYCLES = modem_cfg_pkg::CYC_RES3
) (
	input wire logic ref_clk_in, // reference clock
	input wire logic rst_in, // async reset, high
	input wire logic rx_active_in, // radio in receive
	input wire logic [2:0] rx_time_in, // timeout step
	input wire logic [1:0] wake_poll_resolution_in, // resolution select
	input wire logic qual_in, // quality qualifier bit
	input wire logic rssi_end_in, // end on no carrier
	input wire logic sync_found_in, // sync word seen
	input wire logic preamble_quality_flag_in, // preamble quality reached
	input wire logic carrier_sense_in, // rssi above threshold
	output logic rx_end_out, // one-cycle end request
	output logic running_out, // timer counting
	output logic expired_kept_out // last expiry kept rx
);
	modem_cfg_pkg::timer_state_type state_reg, state_next;
	logic [modem_cfg_pkg::TIMER_W-1:0] count_reg, count_next;
	logic end_reg, end_next;
	logic kept_reg, kept_next;

	// base period per resolution, halved for each step
	function automatic logic [modem_cfg_pkg::TIMER_W-1:0] load_value(
		input logic [1:0] res, input logic [2:0] t);
		logic [modem_cfg_pkg::TIMER_W-1:0] base;
		base = modem_cfg_pkg::TIMER_W'(RES0_CYCLES);
		if (res == 2'h1) base = modem_cfg_pkg::TIMER_W'(RES1_CYCLES);
		else if (res == 2'h2) base = modem_cfg_pkg::TIMER_W'(RES2_CYCLES);
		else if (res == 2'h3) base = modem_cfg_pkg::TIMER_W'(RES3_CYCLES);
		load_value = (base >> t) - modem_cfg_pkg::TIMER_W'(1);
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		end_next = 1'b0;
		kept_next = kept_reg;
		case (state_reg)
			modem_cfg_pkg::TMR_IDLE: begin
				if (rx_active_in && rssi_end_in && !carrier_sense_in) begin
					end_next = 1'b1;
					state_next = modem_cfg_pkg::TMR_DONE;
				end else if (rx_active_in && rx_time_in != modem_cfg_pkg::RX_TIME_NONE) begin
					count_next = load_value(wake_poll_resolution_in, rx_time_in);
					state_next = modem_cfg_pkg::TMR_COUNT;
				end
			end
			modem_cfg_pkg::TMR_COUNT: begin
				if (!rx_active_in) begin
					state_next = modem_cfg_pkg::TMR_IDLE;
				end else if (rssi_end_in && !carrier_sense_in) begin
					end_next = 1'b1;
					state_next = modem_cfg_pkg::TMR_DONE;
				end else if (count_reg == '0) begin
					// sync always keeps rx; preamble quality only with qualifier set
					kept_next = sync_found_in || (qual_in && preamble_quality_flag_in);
					end_next = !kept_next;
					state_next = modem_cfg_pkg::TMR_DONE;
				end else begin
					count_next = count_reg - modem_cfg_pkg::TIMER_W'(1);
				end
			end
			modem_cfg_pkg::TMR_DONE: begin
				// wait for receive to end so one session times out once
				if (!rx_active_in) state_next = modem_cfg_pkg::TMR_IDLE;
			end
			default: state_next = modem_cfg_pkg::TMR_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= modem_cfg_pkg::TMR_IDLE;
			count_reg <= '0;
			end_reg <= 1'b0;
			kept_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			end_reg <= end_next;
			kept_reg <= kept_next;
		end
	end

	assign rx_end_out = end_reg;
	assign running_out = (state_reg == modem_cfg_pkg::TMR_COUNT);
	assign expired_kept_out = kept_reg;
endmodule

// [core/modem_spacing_deviation_rx_timeout.sv]
// modem channel spacing, deviation and receive timeout registers
// assumes an AXI4-Lite master on ref_clk_in and radio status inputs in that domain
`timescale 1ns/1ps
module modem_spacing_deviation_rx_timeout #(
	parameter int RES0_CYCLES = modem_cfg_pkg::CYC_RES0,
	parameter int RES1_CYCLES = modem_cfg_pkg::CYC_RES1,
	parameter int RES2_CYCLES = modem_cfg_pkg::CYC_RES2,
	parameter int RES3_CYCLES = modem_cfg_pkg::CYC_RES3
) (
	input wire logic ref_clk_in, // 10 MHz reference
	input wire logic rst_in, // async reset, high
	input wire logic [9:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [9:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic rx_active_in, // radio in receive
	input wire logic sync_found_in, // sync word found
	input wire logic preamble_quality_flag_in, // preamble quality reached
	input wire logic carrier_sense_in, // rssi above threshold
	output logic [11:0] spacing_out, // spacing, fxosc/2^18 units
	output logic [23:0] frequency_out, // operating frequency word
	output logic [10:0] deviation_out, // deviation, fxosc/2^17 units
	output logic msk_mode_out, // msk selected
	output logic [2:0] msk_phase_fraction_out, // phase change fraction
	output logic rx_end_out // one-cycle end of receive
);
	// ==========================================================
	// register state
	logic [7:0] mant_reg, mant_next;
	logic [7:0] dev_reg, dev_next;
	logic [7:0] tmo_reg, tmo_next;
	logic [1:0] exp_reg, exp_next;
	logic [7:0] channel_number_reg, channel_number_next;
	logic [23:0] base_reg, base_next;
	logic [2:0] mode_reg, mode_next; // [2:1] wake_poll_resolution, [0] msk
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [11:0] spc_reg, spc_next;
	logic [23:0] freq_reg, freq_next;
	logic [10:0] devo_reg, devo_next;
	logic wr_take, rd_take, timer_running, timer_kept;
	logic [7:0] wr_idx, rd_idx;

	// word index from byte address; misaligned bits ignored
	function automatic logic [7:0] word_index(input logic [9:0] addr);
		word_index = addr[9:2];
	endfunction

	// merge one byte lane under its strobe
	function automatic logic [7:0] lane(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic strb);
		lane = strb ? new_v : old_v;
	endfunction

	// ==========================================================
	// handshakes: address and data taken together, one write outstanding
	assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign rd_take = s_axi_arvalid && !rvalid_reg;
	assign s_axi_arready = rd_take;
	assign wr_idx = word_index(s_axi_awaddr);
	assign rd_idx = word_index(s_axi_araddr);

	// ==========================================================
	// register writes and write response
	always_comb begin
		mant_next = mant_reg;
		dev_next = dev_reg;
		tmo_next = tmo_reg;
		exp_next = exp_reg;
		channel_number_next = channel_number_reg;
		base_next = base_reg;
		mode_next = mode_reg;
		bvalid_next = bvalid_reg && !s_axi_bready;
		bresp_next = bresp_reg;
		if (wr_take) begin
			bvalid_next = 1'b1;
			bresp_next = modem_cfg_pkg::RESP_OKAY;
			if (wr_idx == modem_cfg_pkg::IDX_SPACING_MANTISSA) begin
				mant_next = lane(mant_reg, s_axi_wdata[7:0], s_axi_wstrb[0]);
			end else if (wr_idx == modem_cfg_pkg::IDX_MODULATION_DEVIATION) begin
				dev_next = lane(dev_reg, s_axi_wdata[7:0], s_axi_wstrb[0])
					& modem_cfg_pkg::MASK_DEVIATION;
			end else if (wr_idx == modem_cfg_pkg::IDX_RX_TIMEOUT_CONTROL) begin
				tmo_next = lane(tmo_reg, s_axi_wdata[7:0], s_axi_wstrb[0])
					& modem_cfg_pkg::MASK_RX_TIMEOUT;
			end else if (wr_idx == modem_cfg_pkg::IDX_SPACING_EXPONENT) begin
				if (s_axi_wstrb[0]) exp_next = s_axi_wdata[1:0];
			end else if (wr_idx == modem_cfg_pkg::IDX_CHANNEL_NUMBER) begin
				channel_number_next = lane(channel_number_reg, s_axi_wdata[7:0], s_axi_wstrb[0]);
			end else if (wr_idx == modem_cfg_pkg::IDX_BASE_FREQUENCY) begin
				base_next[7:0] = lane(base_reg[7:0], s_axi_wdata[7:0], s_axi_wstrb[0]);
				base_next[15:8] = lane(base_reg[15:8], s_axi_wdata[15:8], s_axi_wstrb[1]);
				base_next[23:16] = lane(base_reg[23:16], s_axi_wdata[23:16], s_axi_wstrb[2]);
			end else if (wr_idx == modem_cfg_pkg::IDX_MODEM_MODE) begin
				// resolution above 1 is legal but gives a tiny polling duty cycle
				if (s_axi_wstrb[0]) mode_next = s_axi_wdata[2:0];
			end else if (wr_idx == modem_cfg_pkg::IDX_SPACING_STATUS ||
				wr_idx == modem_cfg_pkg::IDX_FREQUENCY_STATUS ||
				wr_idx == modem_cfg_pkg::IDX_DEVIATION_STATUS ||
				wr_idx == modem_cfg_pkg::IDX_TIMER_STATUS) begin
				bresp_next = modem_cfg_pkg::RESP_OKAY; // read-only, write ignored
			end else begin
				bresp_next = modem_cfg_pkg::RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// read path, one read outstanding
	always_comb begin
		rvalid_next = rvalid_reg && !s_axi_rready;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (rd_take) begin
			rvalid_next = 1'b1;
			rresp_next = modem_cfg_pkg::RESP_OKAY;
			rdata_next = 32'h00000000;
			if (rd_idx == modem_cfg_pkg::IDX_SPACING_MANTISSA) begin
				rdata_next[7:0] = mant_reg;
			end else if (rd_idx == modem_cfg_pkg::IDX_MODULATION_DEVIATION) begin
				rdata_next[7:0] = dev_reg & modem_cfg_pkg::MASK_DEVIATION;
			end else if (rd_idx == modem_cfg_pkg::IDX_RX_TIMEOUT_CONTROL) begin
				rdata_next[7:0] = tmo_reg & modem_cfg_pkg::MASK_RX_TIMEOUT;
			end else if (rd_idx == modem_cfg_pkg::IDX_SPACING_EXPONENT) begin
				rdata_next[1:0] = exp_reg;
			end else if (rd_idx == modem_cfg_pkg::IDX_CHANNEL_NUMBER) begin
				rdata_next[7:0] = channel_number_reg;
			end else if (rd_idx == modem_cfg_pkg::IDX_BASE_FREQUENCY) begin
				rdata_next[23:0] = base_reg;
			end else if (rd_idx == modem_cfg_pkg::IDX_MODEM_MODE) begin
				rdata_next[2:0] = mode_reg;
			end else if (rd_idx == modem_cfg_pkg::IDX_SPACING_STATUS) begin
				rdata_next[11:0] = spc_reg;
			end else if (rd_idx == modem_cfg_pkg::IDX_FREQUENCY_STATUS) begin
				rdata_next[23:0] = freq_reg;
			end else if (rd_idx == modem_cfg_pkg::IDX_DEVIATION_STATUS) begin
				rdata_next[10:0] = devo_reg;
			end else if (rd_idx == modem_cfg_pkg::IDX_TIMER_STATUS) begin
				rdata_next[1:0] = {timer_kept, timer_running};
			end else begin
				rresp_next = modem_cfg_pkg::RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// derived frequencies, registered so outputs lag config by one cycle, frequency_out by two after a spacing change
	always_comb begin
		// operands widened first so the shift and the product keep their top bits
		spc_next = ({2'h0, modem_cfg_pkg::SPACING_OFFSET} + {4'h0, mant_reg}) << exp_reg;
		// frequency word wraps at 24 bits, as the synthesizer word does
		freq_next = base_reg + ({16'h0000, channel_number_reg} * {12'h000, spc_reg});
		if (mode_reg[0]) begin
			devo_next = 11'h000;
		end else begin
			devo_next = ({7'h00, modem_cfg_pkg::DEVIATION_OFFSET} + {8'h00, dev_reg[2:0]})
				<< dev_reg[modem_cfg_pkg::DEV_EXP_LSB +: 3];
		end
	end

	// all registers
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mant_reg <= modem_cfg_pkg::RST_SPACING_MANTISSA;
			dev_reg <= modem_cfg_pkg::RST_MODULATION_DEVIATION;
			tmo_reg <= modem_cfg_pkg::RST_RX_TIMEOUT_CONTROL;
			exp_reg <= modem_cfg_pkg::RST_SPACING_EXPONENT;
			channel_number_reg <= modem_cfg_pkg::RST_CHANNEL_NUMBER;
			base_reg <= modem_cfg_pkg::RST_BASE_FREQUENCY;
			mode_reg <= modem_cfg_pkg::RST_MODEM_MODE;
			bvalid_reg <= 1'b0;
			bresp_reg <= modem_cfg_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= modem_cfg_pkg::RESP_OKAY;
			rdata_reg <= 32'h00000000;
			spc_reg <= 12'h000;
			freq_reg <= 24'h000000;
			devo_reg <= 11'h000;
		end else begin
			mant_reg <= mant_next;
			dev_reg <= dev_next;
			tmo_reg <= tmo_next;
			exp_reg <= exp_next;
			channel_number_reg <= channel_number_next;
			base_reg <= base_next;
			mode_reg <= mode_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			spc_reg <= spc_next;
			freq_reg <= freq_next;
			devo_reg <= devo_next;
		end
	end

	// ==========================================================
	// receive timeout timer
	rx_timeout_timer #(
		.RES0_CYCLES(RES0_CYCLES),
		.RES1_CYCLES(RES1_CYCLES),
		.RES2_CYCLES(RES2_CYCLES),
		.RES3_CYCLES(RES3_CYCLES)
	) u_timer (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.rx_active_in(rx_active_in),
		.rx_time_in(tmo_reg[2:0]),
		.wake_poll_resolution_in(mode_reg[2:1]),
		.qual_in(tmo_reg[modem_cfg_pkg::TO_QUAL_BIT]),
		.rssi_end_in(tmo_reg[modem_cfg_pkg::TO_RSSI_BIT]),
		.sync_found_in(sync_found_in),
		.preamble_quality_flag_in(preamble_quality_flag_in),
		.carrier_sense_in(carrier_sense_in),
		.rx_end_out(rx_end_out),
		.running_out(timer_running),
		.expired_kept_out(timer_kept)
	);

	// ==========================================================
	// outputs
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign spacing_out = spc_reg;
	assign frequency_out = freq_reg;
	assign deviation_out = devo_reg;
	assign msk_mode_out = mode_reg[0];
	assign msk_phase_fraction_out = dev_reg[2:0];
endmodule

// [verif/modem_spacing_deviation_rx_timeout_checker.sv]
// port-level checker for the modem spacing, deviation and timeout block
// assumes one clock domain and the asynchronous active-high reset
`timescale 1ns/1ps
module modem_cfg_checker #(
	parameter int RES0_CYCLES = modem_cfg_pkg::CYC_RES0,
	parameter int RES1_CYCLES = modem_cfg_pkg::CYC_RES1,
	parameter int RES2_CYCLES = modem_cfg_pkg::CYC_RES2,
	parameter int RES3_CYCLES = modem_cfg_pkg::CYC_RES3
) (
	input wire logic ref_clk_in, // clock
	input wire logic rst_in, // reset
	input wire logic s_axi_awvalid, // write address valid
	input wire logic s_axi_wvalid, // write data valid
	input wire logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [9:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic rx_active_in, // radio in receive
	input wire logic [11:0] spacing_out, // spacing
	input wire logic [10:0] deviation_out, // deviation
	input wire logic msk_mode_out, // msk selected
	input wire logic rx_end_out // end of receive
);
	logic dev_ok;
	logic sp_ok;
	logic live_reg;
	logic live_next;
	// ==========================================================
	// shape of the derived values: a mantissa with its top bit set, shifted
	always_comb begin
		dev_ok = 1'b0;
		sp_ok = 1'b0;
		for (int e = 0; e < 8; e++) begin
			if ((deviation_out >> (e + 3)) == 11'h1 && ((deviation_out >> e) << e) == deviation_out) begin
				dev_ok = 1'b1;
			end
			if (e < 4 && (spacing_out >> (e + 8)) == 12'h1 && ((spacing_out >> e) << e) == spacing_out) begin
				sp_ok = 1'b1;
			end
		end
	end
	// outputs read zero in reset, so shape is judged only from the second edge on
	always_comb live_next = 1'b1;
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) live_reg <= 1'b0;
		else live_reg <= live_next;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// ==========================================================
	// assertions
	spacing_shape_a: assert property (live_reg |-> sp_ok)
		else $error("spacing output is not a shifted mantissa");
	dev_shape_a: assert property (live_reg && !msk_mode_out && !$past(msk_mode_out) |-> dev_ok)
		else $error("deviation output is not a shifted mantissa");
	msk_dev_zero_a: assert property (msk_mode_out && $past(msk_mode_out) |-> deviation_out == 11'h0)
		else $error("deviation output not zero in msk mode");
	write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
		else $error("write response missing");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
		else $error("read response missing");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	unmapped_read_a: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr[9:2] > 8'h16 |=>
		s_axi_rresp == modem_cfg_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	end_pulse_a: assert property (rx_end_out |=> !rx_end_out)
		else $error("end request longer than one cycle");
	end_in_rx_a: assert property (rx_end_out |-> $past(rx_active_in))
		else $error("end request outside receive");
	end_cov: cover property (rx_end_out);
	msk_cov: cover property (msk_mode_out);
	slverr_cov: cover property (s_axi_rvalid && s_axi_rresp == modem_cfg_pkg::RESP_SLVERR);
endmodule

bind modem_spacing_deviation_rx_timeout modem_cfg_checker #(
	.RES0_CYCLES(RES0_CYCLES), .RES1_CYCLES(RES1_CYCLES),
	.RES2_CYCLES(RES2_CYCLES), .RES3_CYCLES(RES3_CYCLES)
) checker_i (
	.ref_clk_in, .rst_in, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .rx_active_in, .spacing_out, .deviation_out, .msk_mode_out, .rx_end_out
);

// [verif/modem_spacing_deviation_rx_timeout_tb.sv]
// self-checking bench for the modem spacing, deviation and timeout block
// assumes short timer counts so each receive session ends within a hundred cycles
`timescale 1ns/1ps
module modem_spacing_deviation_rx_timeout_tb;
	localparam int BASE [4] = '{64, 320, 576, 832};
	logic ref_clk_in, rst_in;
	logic [9:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic rx_active_in, sync_found_in, preamble_quality_flag_in, carrier_sense_in;
	logic [11:0] spacing_out;
	logic [23:0] frequency_out;
	logic [10:0] deviation_out;
	logic [2:0] msk_phase_fraction_out;
	logic msk_mode_out, rx_end_out;
	logic [31:0] d;
	logic [1:0] r;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc;
	modem_spacing_deviation_rx_timeout #(.RES0_CYCLES(64), .RES1_CYCLES(320),
		.RES2_CYCLES(576), .RES3_CYCLES(832)) modem_spacing_deviation_rx_timeout_i (
		.ref_clk_in, .rst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rx_active_in, .sync_found_in, .preamble_quality_flag_in, .carrier_sense_in,
		.spacing_out, .frequency_out, .deviation_out, .msk_mode_out, .msk_phase_fraction_out,
		.rx_end_out);
	// ==========================================================
	// common tasks
	task summarize;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// address and data offered together; bready stays high so back-to-back calls
	// never assign it twice in one step; only the watchdog ends a wait
	task wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] resp);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk_in); while ((s_axi_awready && s_axi_wready) !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge ref_clk_in); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
	endtask
	task rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk_in); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk_in); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	// one receive session; cyc equals lim when no end request came
	task rx_run(input int lim);
		rx_active_in <= 1'b1;
		cyc = 0;
		do begin @(posedge ref_clk_in); cyc++; end while (rx_end_out !== 1'b1 && cyc < lim);
		rx_active_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
	endtask
	// ==========================================================
	// scenarios
	task t_reset;
		rd(10'h050, d, r); chk("mantissa reset", d, 32'hF8);
		rd(10'h054, d, r); chk("deviation reset", d, 32'h47);
		rd(10'h058, d, r); chk("timeout reset", d, 32'h07);
		chk("spacing reset", 32'(spacing_out), 32'h7E0);
		chk("deviation out reset", 32'(deviation_out), 32'hF0);
	endtask
	task t_spacing;
		wr(10'h050, 32'hFFFFFFA5, r);
		rd(10'h050, d, r); chk("mantissa rw", d, 32'hA5);
		wr(10'h004, 32'h3, r);
		wr(10'h008, 32'h1000, r);
		for (int e = 0; e < 4; e++) begin
			wr(10'h000, 32'(e), r);
			repeat (3) @(posedge ref_clk_in);
			chk("spacing", 32'(spacing_out), 32'(421 << e));
			chk("frequency", 32'(frequency_out), 32'(4096 + 3 * (421 << e)));
		end
	endtask
	task t_deviation;
		wr(10'h054, 32'hFF, r);
		rd(10'h054, d, r); chk("deviation reserved", d, 32'h77);
		for (int e = 0; e < 8; e++) begin
			wr(10'h054, 32'((e << 4) | 5), r);
			repeat (3) @(posedge ref_clk_in);
			chk("deviation", 32'(deviation_out), 32'(13 << e));
		end
		wr(10'h00C, 32'h1, r);
		repeat (3) @(posedge ref_clk_in);
		chk("msk mode", 32'(msk_mode_out), 32'h1);
		chk("msk deviation", 32'(deviation_out), 32'h0);
		chk("msk fraction", 32'(msk_phase_fraction_out), 32'h5);
		wr(10'h00C, 32'h0, r);
	endtask
	// mixes resolution and step so that halving and the table columns both show
	task t_timeout;
		int rs [6] = '{0, 0, 0, 1, 2, 3};
		int ts [6] = '{0, 2, 5, 3, 4, 6};
		int n;
		wr(10'h058, 32'hFF, r);
		rd(10'h058, d, r); chk("timeout reserved", d, 32'h1F);
		for (int i = 0; i < 6; i++) begin
			wr(10'h00C, 32'(rs[i] << 1), r);
			wr(10'h058, 32'(ts[i]), r);
			n = BASE[rs[i]] >> ts[i];
			rx_run(n + 40);
			chk("timeout length", 32'(cyc >= n && cyc <= n + 5), 32'h1);
		end
		wr(10'h00C, 32'h0, r); // polling resolution back to 0
	endtask
	task t_qual;
		logic q [5] = '{0, 0, 1, 1, 0};
		logic s [5] = '{1, 0, 0, 1, 0};
		logic p [5] = '{0, 1, 1, 0, 0};
		logic e [5] = '{0, 1, 0, 0, 1};
		for (int i = 0; i < 5; i++) begin
			wr(10'h058, 32'((q[i] << 3) | 3), r);
			sync_found_in <= s[i];
			preamble_quality_flag_in <= p[i];
			rx_run(40);
			chk("qualified end", 32'(cyc < 40), 32'(e[i]));
			rd(10'h01C, d, r); chk("kept status", d, 32'(!e[i]) << 1);
		end
		sync_found_in <= 1'b0;
		preamble_quality_flag_in <= 1'b0;
	endtask
	task t_rssi;
		carrier_sense_in <= 1'b0;
		wr(10'h058, 32'h17, r);
		rx_run(30); chk("rssi end", 32'(cyc <= 4), 32'h1);
		carrier_sense_in <= 1'b1;
		rx_run(30); chk("carrier keeps rx", 32'(cyc), 32'd30);
		carrier_sense_in <= 1'b0;
		wr(10'h058, 32'h07, r);
		rx_run(30); chk("no timeout step 7", 32'(cyc), 32'd30);
		carrier_sense_in <= 1'b1;
	endtask
	task t_unmapped;
		rd(10'h3FC, d, r);
		chk("unmapped read resp", 32'(r), 32'h2);
		chk("unmapped read data", d, 32'h0);
		wr(10'h3FC, 32'h5A, r); chk("unmapped write resp", 32'(r), 32'h2);
	endtask
	// ==========================================================
	// clock, watchdog and main sequence
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	// the whole run needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		error_cnt++;
		summarize;
	end
	initial begin
		rst_in = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{rx_active_in, sync_found_in, preamble_quality_flag_in} = '0;
		carrier_sense_in = 1'b1;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		t_reset;
		t_spacing;
		t_deviation;
		t_timeout;
		t_qual;
		t_rssi;
		t_unmapped;
		summarize;
	end
endmodule
